/* rtl/spi_ss_port.sv */
// Purpose: synchronous serial port, slave select and sleep behaviour
// Assumes: AXI4-Lite register access, pins sampled on clock
// Notes: irq also serves as the wake request while asleep
//
// Notes on behaviour
// - master idles select high; each falling select starts a new frame
// - select returning high resets the slave, discarding partial bytes
// - select control only in mode field encoding 0100
// - select low in that mode enables shifting and drives data out
// - select high releases data out at once, even mid-byte; here three clocks after the pin, through the synchroniser
// - port reset clears bit counter; by select high or enable cleared
// - master transfer freezes in sleep and resumes after
// - slave shifts on external clock in sleep; byte sets flag, wakes
// - control one: collision 7, overflow 6, enable 5, idle 4, mode 3:0
// - data shifts most significant bit first
// - eighth bit loads buffer, sets buffer full and interrupt flag
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "spi_ss_params.svh"
module spi_ss_port (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sleep,
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic sdi_in,
  output logic sck_out,
  output logic sck_oe,
  output logic sdo_out,
  output logic sdo_oe,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  function automatic spi_ss_pkg::reg_sel_t decode(input logic [7:0] a);
    case (a)
      `OFS_BUF: decode = spi_ss_pkg::SEL_BUF;
      `OFS_CON1: decode = spi_ss_pkg::SEL_CON1;
      `OFS_CON3: decode = spi_ss_pkg::SEL_CON3;
      `OFS_STAT: decode = spi_ss_pkg::SEL_STAT;
      `OFS_IEN: decode = spi_ss_pkg::SEL_IEN;
      `OFS_IFL: decode = spi_ss_pkg::SEL_IFL;
      default: decode = spi_ss_pkg::SEL_NONE;
    endcase
  endfunction : decode

  logic [2:0] pins_s;
  logic sck_s, ss_n_s, sdi_s;
  logic sck_prev_q;
  logic [7:0] con1_q, con3_q, stat_q, buf_q, sr_q;
  logic ien_q, iflag_q, rx_bit_q;
  logic [2:0] cnt_q;
  spi_ss_pkg::mst_state_t mst_q;
  logic [5:0] div_q;
  logic [4:0] tog_q;
  logic [5:0] half;
  logic en, is_slave, is_master, ss_mode, slv_active, port_rst;
  logic m_tog, lead, trail, sample_edge, tx_edge, byte_done, busy;
  logic wr_go, wr_lo, rd_go, buf_wr, buf_rd, keep_rx;
  spi_ss_pkg::reg_sel_t wsel, rsel;

  ////////////////////////////////////////////////////////////////////
  // pin sampling

  spi_pin_sync pin_sync (
    .clock(clock),
    .reset_n(reset_n),
    .pins({sck_in, ss_n_in, sdi_in}),
    .pins_s(pins_s)
  );
  assign sck_s = pins_s[2];
  assign ss_n_s = pins_s[1];
  assign sdi_s = pins_s[0];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mode decode and edges

  assign en = con1_q[`C1_EN];
  assign ss_mode = con1_q[3:0] == `MODE_SLV_SS;
  assign is_slave = en && (ss_mode || con1_q[3:0] == `MODE_SLV);
  assign is_master = en && (con1_q[3:0] == `MODE_M4 ||
    con1_q[3:0] == `MODE_M16 || con1_q[3:0] == `MODE_M64);
  // in mode 0100, select high holds the slave in reset, so a missed bit never carries on
  assign port_rst = !en || (is_slave && ss_mode && ss_n_s);
  assign slv_active = is_slave && !port_rst;

  always_comb begin
    case (con1_q[3:0])
      `MODE_M16: half = `HALF_M16;
      `MODE_M64: half = `HALF_M64;
      default: half = `HALF_M4;
    endcase
  end

  // sleep stops the master clock generator only; slave edges keep coming
  assign m_tog = mst_q == spi_ss_pkg::M_RUN && !sleep &&
    div_q == half - 6'h01;

  always_comb begin
    if (is_master) begin
      lead = m_tog && sck_out == con1_q[`C1_IDLE];
      trail = m_tog && sck_out != con1_q[`C1_IDLE];
    end else begin
      lead = slv_active && sck_s != con1_q[`C1_IDLE] &&
        sck_prev_q == con1_q[`C1_IDLE];
      trail = slv_active && sck_s == con1_q[`C1_IDLE] &&
        sck_prev_q != con1_q[`C1_IDLE];
    end
  end

  assign sample_edge = stat_q[`ST_CKE] ? lead : trail;
  assign tx_edge = stat_q[`ST_CKE] ? trail : lead;
  assign byte_done = sample_edge && cnt_q == `LAST_BIT;
  assign busy = cnt_q != 3'h0 || mst_q == spi_ss_pkg::M_RUN;
  assign keep_rx = !stat_q[`ST_FULL] || con3_q[`C3_BOEN];

  ////////////////////////////////////////////////////////////////////
  // bus handshake

  assign wsel = decode(s_axi_awaddr);
  assign rsel = decode(s_axi_araddr);
  assign wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign wr_lo = wr_go && s_axi_wstrb[0];
  assign rd_go = s_axi_arready && s_axi_arvalid;
  assign buf_wr = wr_lo && wsel == spi_ss_pkg::SEL_BUF;
  assign buf_rd = rd_go && rsel == spi_ss_pkg::SEL_BUF;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
        !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
        !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wsel == spi_ss_pkg::SEL_NONE ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (rsel)
          spi_ss_pkg::SEL_BUF: s_axi_rdata <= {24'h0, buf_q};
          spi_ss_pkg::SEL_CON1: s_axi_rdata <= {24'h0, con1_q};
          spi_ss_pkg::SEL_CON3: s_axi_rdata <= {24'h0, con3_q};
          spi_ss_pkg::SEL_STAT: s_axi_rdata <= {24'h0, stat_q};
          spi_ss_pkg::SEL_IEN: s_axi_rdata <= {28'h0, ien_q, 3'h0};
          spi_ss_pkg::SEL_IFL: s_axi_rdata <= {28'h0, iflag_q, 3'h0};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers; hardware set wins over a software clear

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      con1_q <= `RST_BYTE;
    end else begin
      if (wr_lo && wsel == spi_ss_pkg::SEL_CON1) begin
        con1_q <= s_axi_wdata[7:0];
      end
      if (buf_wr && busy) begin
        con1_q[`C1_COLL] <= 1'b1;
      end
      if (byte_done && !keep_rx) begin
        con1_q[`C1_OV] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      con3_q <= `RST_BYTE;
      ien_q <= 1'b0;
    end else begin
      if (wr_lo && wsel == spi_ss_pkg::SEL_CON3) begin
        con3_q <= s_axi_wdata[7:0];
      end
      if (wr_lo && wsel == spi_ss_pkg::SEL_IEN) begin
        ien_q <= s_axi_wdata[`IRQ_BIT];
      end
    end
  end

  // only the two upper status bits are writable; buffer full is hardware
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= `RST_BYTE;
    end else begin
      if (wr_lo && wsel == spi_ss_pkg::SEL_STAT) begin
        stat_q[`ST_PHASE] <= s_axi_wdata[`ST_PHASE];
        stat_q[`ST_CKE] <= s_axi_wdata[`ST_CKE];
      end
      if (byte_done) begin
        stat_q[`ST_FULL] <= 1'b1;
      end else if (buf_rd) begin
        stat_q[`ST_FULL] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      iflag_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (byte_done) begin
        iflag_q <= 1'b1;
      end else if (wr_lo && wsel == spi_ss_pkg::SEL_IFL &&
          s_axi_wdata[`IRQ_BIT]) begin
        iflag_q <= 1'b0;
      end
      irq <= iflag_q && ien_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // shift engine

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 3'h0;
      rx_bit_q <= 1'b0;
    end else if (port_rst) begin
      cnt_q <= 3'h0;
    end else if (sample_edge) begin
      cnt_q <= cnt_q + 3'h1;
      rx_bit_q <= sdi_s;
    end
  end

  // the first transmit edge of a mode without the leading edge holds msb
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sr_q <= `RST_BYTE;
    end else if (buf_wr && !busy) begin
      sr_q <= s_axi_wdata[7:0];
    end else if (tx_edge && cnt_q != 3'h0 && !port_rst) begin
      sr_q <= {sr_q[6:0], rx_bit_q};
    end
  end

  // overwrite of an unread byte only with buffer overwrite enabled
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      buf_q <= `RST_BYTE;
    end else if (buf_wr && !busy) begin
      buf_q <= s_axi_wdata[7:0];
    end else if (byte_done && keep_rx) begin
      buf_q <= {sr_q[6:0], sdi_s};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // master clock generator

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mst_q <= spi_ss_pkg::M_IDLE;
      div_q <= 6'h0;
      tog_q <= 5'h0;
      sck_out <= 1'b0;
    end else begin
      case (mst_q)
        spi_ss_pkg::M_IDLE: begin
          div_q <= 6'h0;
          tog_q <= 5'h0;
          sck_out <= con1_q[`C1_IDLE];
          if (buf_wr && !busy && is_master) begin
            mst_q <= spi_ss_pkg::M_RUN;
          end
        end
        spi_ss_pkg::M_RUN: begin
          if (!is_master) begin
            mst_q <= spi_ss_pkg::M_IDLE;
          end else if (m_tog) begin
            div_q <= 6'h0;
            sck_out <= !sck_out;
            tog_q <= tog_q + 5'h1;
            if (tog_q == `TOGGLES - 5'h1) begin
              mst_q <= spi_ss_pkg::M_IDLE;
            end
          end else if (!sleep) begin
            div_q <= div_q + 6'h1;
          end
        end
        default: mst_q <= spi_ss_pkg::M_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin drive

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
      sck_oe <= 1'b0;
    end else begin
      sdo_out <= sr_q[7];
      // released from the synchronised select, three clocks after the pin
      sdo_oe <= is_master || slv_active;
      sck_oe <= is_master;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  cnt_reset_a: assert property (@(posedge clock) disable iff (!reset_n)
    port_rst |=> cnt_q == 3'h0)
    else $error("bit counter not cleared by port reset");

  sdo_float_a: assert property (@(posedge clock) disable iff (!reset_n)
    is_slave && ss_mode && ss_n_s |=> !sdo_oe)
    else $error("data out driven while select high");

  sdo_drive_a: assert property (@(posedge clock) disable iff (!reset_n)
    is_slave && ss_mode && !ss_n_s |=> sdo_oe)
    else $error("data out not driven while select low");

  frame_start_a: assert property (@(posedge clock) disable iff (!reset_n)
    is_slave && ss_mode && $fell(ss_n_s) |-> cnt_q == 3'h0)
    else $error("frame did not start aligned");

  select_mode_a: assert property (@(posedge clock) disable iff (!reset_n)
    en && con1_q[3:0] == `MODE_SLV |-> !port_rst)
    else $error("select acted outside select mode");

  byte_flags_a: assert property (@(posedge clock) disable iff (!reset_n)
    byte_done |=> iflag_q && stat_q[`ST_FULL] ##1 irq == ien_q)
    else $error("byte end did not raise flags");

  msb_first_a: assert property (@(posedge clock) disable iff (!reset_n)
    byte_done && keep_rx && !buf_wr |=> buf_q == {$past(sr_q[6:0]), $past(sdi_s)})
    else $error("received byte misordered");

  sleep_freeze_a: assert property (@(posedge clock) disable iff (!reset_n)
    mst_q == spi_ss_pkg::M_RUN && is_master && sleep |=> $stable(sck_out) &&
      $stable(div_q))
    else $error("master moved during sleep");

  slave_sleep_a: assert property (@(posedge clock) disable iff (!reset_n)
    sleep && byte_done |=> iflag_q)
    else $error("slave byte lost in sleep");

endmodule : spi_ss_port
`default_nettype wire

/* include/spi_ss_params.svh */
// Purpose: constants of the serial port slave-select block
// Assumes: included by bare name
// Notes: offsets are byte addresses on the register bus
`ifndef SPI_SS_PARAMS_SVH
`define SPI_SS_PARAMS_SVH
`define OFS_BUF 8'h00
`define OFS_CON1 8'h04
`define OFS_CON3 8'h08
`define OFS_STAT 8'h0c
`define OFS_IEN 8'h10
`define OFS_IFL 8'h14
`define C1_COLL 7
`define C1_OV 6
`define C1_EN 5
`define C1_IDLE 4
`define ST_PHASE 7
`define ST_CKE 6
`define ST_FULL 0
`define C3_BOEN 4
`define IRQ_BIT 3
`define MODE_M4 4'h0
`define MODE_M16 4'h1
`define MODE_M64 4'h2
`define MODE_SLV_SS 4'h4
`define MODE_SLV 4'h5
`define HALF_M4 6'h02
`define HALF_M16 6'h08
`define HALF_M64 6'h20
`define TOGGLES 5'h10
`define LAST_BIT 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RST_BYTE 8'h00
`endif

/* include/spi_ss_pkg.sv */
// Purpose: types of the serial port slave-select block
// Assumes: nothing
// Notes: constants live in spi_ss_params.svh
package spi_ss_pkg;
  typedef enum logic {M_IDLE, M_RUN} mst_state_t;
  typedef enum logic [2:0] {
    SEL_BUF, SEL_CON1, SEL_CON3, SEL_STAT, SEL_IEN, SEL_IFL, SEL_NONE
  } reg_sel_t;
endpackage : spi_ss_pkg

/* rtl/spi_pin_sync.sv */
// Purpose: two-flop synchroniser for the serial pins
// Assumes: pins are asynchronous to clock
// Notes: only the second stage leaves this module
`timescale 1ns/10ps
`default_nettype none
module spi_pin_sync (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [2:0] pins,
  output logic [2:0] pins_s
);
  logic [2:0] meta_q;

  // idle levels: clock low, select high, data low
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 3'h2;
      pins_s <= 3'h2;
    end else begin
      meta_q <= pins;
      pins_s <= meta_q;
    end
  end
endmodule : spi_pin_sync
`default_nettype wire

/* verif/spi_master_model.sv */
// Purpose: behavioural spi master facing the serial port pins
// Assumes: clock idles low, data changes on the falling edge
// Notes: link clock stands still between frames
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
  input wire logic sdo,
  output logic sck,
  output logic ss_n,
  output logic sdi,
  output logic [7:0] rx_byte,
  output logic rx_done
);
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    sdi = 1'b0;
    rx_byte = 8'h00;
    rx_done = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // samples late in the high phase: slave output lags by its pin sync
  task automatic frame(input logic [7:0] tx, input int nbits, input bit hold);
    ss_n = 1'b0;
    #64;
    for (int i = 7; i > 7 - nbits; i--) begin
      sdi = tx[i];
      #16 sck = 1'b1;
      #15 rx_byte[i] = sdo;
      #1 sck = 1'b0;
    end
    sdi = ~sdi;
    if (nbits == 8) begin
      rx_done = 1'b1;
      #1 rx_done = 1'b0;
    end
    if (!hold) end_sel();
  endtask : frame
  task automatic end_sel;
    #48 ss_n = 1'b1;
  endtask : end_sel
endmodule : spi_master_model
`default_nettype wire

/* verif/test_spi_ss_port.sv */
// Purpose: self-checking bench of the serial port slave-select block
// Assumes: slave mode 0100 with clock edge select set, idle low clock
// Notes: expectations are queued by drivers, compared by monitors
`timescale 1ns/10ps
`default_nettype none
`include "spi_ss_params.svh"
module test_spi_ss_port;
  logic clock, reset_n, sleep, sck_out, sck_oe, sdo_out, sdo_oe, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rx_byte, tx, mx;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic m_sck, m_ss_n, m_sdi, rx_done, sck_prev, sdo_last;
  wire logic sck_w, sdo_w;
  logic [33:0] exp_q[$];
  logic [1:0] resp_q[$];
  logic [7:0] byte_q[$];
  int seed, check_count, bad_count, tog, t0, t1;
  assign sck_w = sck_oe ? sck_out : m_sck;
  // released data line flips so a stale bit cannot pass
  assign sdo_w = sdo_oe ? sdo_out : ~sdo_last;
  spi_ss_port spi_ss_port_inst (
    .clock, .reset_n, .sleep, .sck_in(sck_w), .ss_n_in(m_ss_n), .sdi_in(m_sdi),
    .sck_out, .sck_oe, .sdo_out, .sdo_oe, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  spi_master_model spi_master_model_inst (
    .sdo(sdo_w), .sck(m_sck), .ss_n(m_ss_n), .sdi(m_sdi), .rx_byte, .rx_done
  );
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic tally(input logic [33:0] g, input logic [33:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : tally
  task automatic cmp_word(input logic [33:0] g, input logic [33:0] e);
    tally(g, e);
  endtask : cmp_word
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    tally({26'h0000000, g}, {26'h0000000, e});
  endtask : cmp_byte
  task automatic cmp_flag(input logic [31:0] g, input logic [31:0] e);
    tally({2'b00, g}, {2'b00, e});
  endtask : cmp_flag
  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
    tally({32'h00000000, g}, {32'h00000000, e});
  endtask : cmp_resp
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////////////////////
  // handshakes are judged at the falling edge, where registered outputs are settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs = `RESP_OKAY);
    logic aw, w, b;
    @(posedge clock);
    resp_q.push_back(rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clock);
      aw = s_axi_awvalid && !s_axi_awready;
      w = s_axi_wvalid && !s_axi_wready;
      b = !s_axi_bvalid;
      @(posedge clock);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      s_axi_bready <= b;
    end while (b);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs = `RESP_OKAY);
    logic ar, r;
    @(posedge clock);
    exp_q.push_back({rs, 24'h000000, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock);
      ar = s_axi_arvalid && !s_axi_arready;
      r = !s_axi_rvalid;
      @(posedge clock);
      s_axi_arvalid <= ar;
      s_axi_rready <= r;
    end while (r);
  endtask : rd
  always @(negedge clock) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      cmp_word({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      cmp_resp(s_axi_bresp, resp_q.pop_front());
    end
    if (sck_out !== sck_prev) tog++;
    sck_prev = sck_out;
    if (sdo_oe === 1'b1) sdo_last = sdo_out;
  end
  always @(posedge rx_done) begin
    cmp_byte(rx_byte, byte_q.pop_front());
  end
  task automatic slave_byte(input logic [7:0] t, input logic [7:0] m);
    wr(`OFS_BUF, t);
    byte_q.push_back(t);
    spi_master_model_inst.frame(m, 8, 1'b0);
    repeat (10) @(posedge clock);
  endtask : slave_byte
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {sleep, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h000000000000;
    s_axi_wstrb = 4'hf;
    seed = 32'h5c80;
    reset_n = 1'b0;
    sdo_last = 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    rd(`OFS_CON1, `RST_BYTE);
    rd(8'h18, 8'h00, `RESP_SLVERR);
    wr(8'h18, 8'h00, `RESP_SLVERR);
    wr(`OFS_STAT, 8'h40);
    wr(`OFS_IEN, 8'h08);
    wr(`OFS_CON1, 8'h24);
    rd(`OFS_CON1, 8'h24);
    for (int i = 0; i < 2; i++) begin
      tx = 8'($random(seed));
      mx = 8'($random(seed));
      sleep <= i[0];
      slave_byte(tx, mx);
      cmp_flag(irq, 32'h1);
      rd(`OFS_STAT, 8'h41);
      rd(`OFS_BUF, mx);
      rd(`OFS_IFL, 8'h08);
      wr(`OFS_IFL, 8'h08);
      sleep <= 1'b0;
      repeat (2) @(posedge clock);
      cmp_flag(irq, 32'h0);
    end
    // a cut-short frame must leave the next one aligned
    wr(`OFS_BUF, 8'h3c);
    spi_master_model_inst.frame(8'hff, 3, 1'b1);
    cmp_flag(sdo_oe, 32'h1);
    spi_master_model_inst.end_sel();
    repeat (6) @(posedge clock);
    cmp_flag(sdo_oe, 32'h0);
    slave_byte(8'h81, 8'h5a);
    rd(`OFS_BUF, 8'h5a);
    wr(`OFS_IFL, 8'h08);
    wr(`OFS_IEN, 8'h00);
    slave_byte(8'h66, 8'hc3);
    cmp_flag(irq, 32'h0);
    rd(`OFS_IFL, 8'h08);
    rd(`OFS_BUF, 8'hc3);
    // every master rate; sleep lands before the first toggle of each
    for (int j = 0; j < 3; j++) begin
      wr(`OFS_CON1, 8'h20 | 8'(j));
      t0 = tog;
      wr(`OFS_BUF, 8'ha5);
      sleep <= 1'b1;
      repeat (2) @(posedge clock);
      t1 = tog;
      repeat (40) @(posedge clock);
      cmp_flag(tog - t1, 32'h0);
      cmp_flag(sck_oe, 32'h1);
      sleep <= 1'b0;
      repeat (600) @(posedge clock);
      cmp_flag(tog - t0, `TOGGLES);
    end
    // slave without select: select pin has no say, data out stays driven
    wr(`OFS_CON1, 8'h25);
    repeat (4) @(posedge clock);
    cmp_flag(sdo_oe, 32'h1);
    cmp_flag(sck_oe, 32'h0);
    close_out();
  end
endmodule : test_spi_ss_port
`default_nettype wire
